// ==== shared/drive_opt_pkg.sv ====
// Shared constants and types for the drive option strap logic
package drive_opt_pkg;

    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned INDEX_TIMEOUT_MS = 400;
    localparam int unsigned INDEX_TIMEOUT_CYC = (CLK_HZ / 1000) * INDEX_TIMEOUT_MS;
    localparam int unsigned ERASE_DELAY_US = 200;
    localparam int unsigned ERASE_DELAY_CYC = (CLK_HZ / 1_000_000) * ERASE_DELAY_US;
    localparam int unsigned STRAP_SETTLE_CYC = 8;

    // -------------------------------------------------------------
    // Modes
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        STEP_STD_3MS = 2'b00,
        STEP_SELF_SEEK = 2'b01,
        STEP_SLOW_6MS = 2'b10
    } step_mode_t;

    typedef enum logic [1:0] {
        RDY_STD = 2'b00,
        RDY_LATCH = 2'b01,
        RDY_FULL = 2'b10,
        RDY_SPIN = 2'b11
    } ready_mode_t;

    // -------------------------------------------------------------
    // Strap and pin bundles, most significant field first
    // -------------------------------------------------------------
    typedef struct packed {
        logic side_strap_std_a;
        logic side_strap_std_b;
        logic side_from_direction_strap;
        logic ready_alt_pin_strap;
        logic ready_std_pin_strap;
        logic ready_mode_strap_a;
        logic ready_mode_strap_b;
        logic motor_by_select_strap;
        logic slow_step_strap;
        logic self_seek_strap;
        logic stepper_gated_strap;
        logic stepper_always_strap;
        logic disk_present_out_strap;
        logic host_activity_in_strap;
        logic activity_path_strap;
        logic led_select_only_strap;
        logic door_lock_strap;
        logic solenoid_fitted_strap;
        logic protect_enable_strap;
        logic protect_inhibit_strap;
        logic tunnel_erase_strap;
        logic straddle_erase_strap;
    } straps_t;

    typedef struct packed {
        logic drive_sel_b;
        logic motor_on_b;
        logic direction_b;
        logic side_select_b;
        logic write_enable_b;
        logic door_lock_b;
        logic special_in_b;
        logic index_b;
        logic latch_closed;
        logic disk_present;
        logic write_protect;
        logic motor_at_speed;
    } pins_t;

    localparam int unsigned IN_W = $bits(straps_t) + $bits(pins_t);

endpackage

// ==== shared/pin_sync_if.sv ====
// Carrier between the strap logic and its pin filter
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ==== verilog/pin_filter.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    pin_sync_if.filt sync
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;

    if (W < 1) begin : g_bad_width
        $error("pin_filter width must be at least one");
    end

    // First stage feeds only the second; agreement of two and three counts
    always_comb begin
        d = q;
        d.s1 = sync.raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.clean[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync.clean = q.clean;

endmodule

// ==== verilog/drive_option_strap_logic.sv ====
// Strap-selected option logic of a flexible disk drive
`timescale 1ns/1ps

module drive_option_strap_logic #(
    parameter int unsigned INDEX_TIMEOUT_CYC = drive_opt_pkg::INDEX_TIMEOUT_CYC,
    parameter int unsigned ERASE_DELAY_CYC = drive_opt_pkg::ERASE_DELAY_CYC,
    parameter int unsigned STRAP_SETTLE_CYC = drive_opt_pkg::STRAP_SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic side_strap_std_a,
    input wire logic side_strap_std_b,
    input wire logic side_from_direction_strap,
    input wire logic ready_alt_pin_strap,
    input wire logic ready_std_pin_strap,
    input wire logic ready_mode_strap_a,
    input wire logic ready_mode_strap_b,
    input wire logic motor_by_select_strap,
    input wire logic slow_step_strap,
    input wire logic self_seek_strap,
    input wire logic stepper_gated_strap,
    input wire logic stepper_always_strap,
    input wire logic disk_present_out_strap,
    input wire logic host_activity_in_strap,
    input wire logic activity_path_strap,
    input wire logic led_select_only_strap,
    input wire logic door_lock_strap,
    input wire logic solenoid_fitted_strap,
    input wire logic protect_enable_strap,
    input wire logic protect_inhibit_strap,
    input wire logic tunnel_erase_strap,
    input wire logic straddle_erase_strap,
    input wire logic drive_sel_b,
    input wire logic motor_on_b,
    input wire logic direction_b,
    input wire logic side_select_b,
    input wire logic write_enable_b,
    input wire logic door_lock_b,
    input wire logic special_in_b,
    input wire logic index_b,
    input wire logic latch_closed,
    input wire logic disk_present,
    input wire logic write_protect,
    input wire logic motor_at_speed,
    output logic straps_valid,
    output logic head_side_one,
    output logic ready_alt_b,
    output logic ready_alt_oe,
    output logic ready_std_b,
    output logic ready_std_oe,
    output logic motor_enable,
    output drive_opt_pkg::step_mode_t step_mode,
    output logic stepper_power,
    output logic special_out_b,
    output logic special_oe,
    output logic activity_led,
    output logic door_solenoid,
    output logic write_gate,
    output logic erase_gate
);
    import drive_opt_pkg::*;

    // -------------------------------------------------------------
    // Sizes and limits
    // -------------------------------------------------------------
    localparam int IDX_W = $clog2(INDEX_TIMEOUT_CYC);
    localparam int ERA_W = $clog2(ERASE_DELAY_CYC);
    localparam int SET_W = $clog2(STRAP_SETTLE_CYC);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(INDEX_TIMEOUT_CYC - 1);
    localparam logic [ERA_W-1:0] ERA_LAST = ERA_W'(ERASE_DELAY_CYC - 1);
    localparam logic [SET_W-1:0] SET_LAST = SET_W'(STRAP_SETTLE_CYC - 1);

    if (INDEX_TIMEOUT_CYC < 2 || ERASE_DELAY_CYC < 2 || STRAP_SETTLE_CYC < 6) begin : g_bad_counts
        $error("timeout and delay counts too small for the counters");
    end

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [SET_W-1:0] settle;
        logic valid;
        straps_t straps;
        logic sel_prev;
        logic stale;
        logic idx_prev_b;
        logic [IDX_W-1:0] idx_timer;
        logic idx_seen;
        logic [ERA_W-1:0] erase_cnt;
        logic side_one;
        logic ready;
        logic ready_alt_b;
        logic ready_alt_oe;
        logic ready_std_b;
        logic ready_std_oe;
        logic motor_en;
        step_mode_t step_mode;
        logic stepper_pwr;
        logic special_b;
        logic special_oe;
        logic led_on;
        logic door_sol;
        logic write_gate;
        logic erase_on;
    } state_t;

    state_t q;
    state_t d;

    function automatic step_mode_t step_sel(input logic slow, input logic seek);
        case ({slow, seek})
            2'b01: step_sel = STEP_SELF_SEEK;
            2'b10: step_sel = STEP_SLOW_6MS;
            default: step_sel = STEP_STD_3MS;
        endcase
    endfunction

    // -------------------------------------------------------------
    // Pin synchronisation
    // -------------------------------------------------------------
    pin_sync_if #(.W(IN_W)) sync ();

    assign sync.raw = {side_strap_std_a, side_strap_std_b, side_from_direction_strap, ready_alt_pin_strap,
                       ready_std_pin_strap, ready_mode_strap_a, ready_mode_strap_b, motor_by_select_strap,
                       slow_step_strap, self_seek_strap, stepper_gated_strap, stepper_always_strap,
                       disk_present_out_strap, host_activity_in_strap, activity_path_strap, led_select_only_strap,
                       door_lock_strap, solenoid_fitted_strap, protect_enable_strap, protect_inhibit_strap,
                       tunnel_erase_strap, straddle_erase_strap, drive_sel_b, motor_on_b, direction_b, side_select_b,
                       write_enable_b, door_lock_b, special_in_b, index_b, latch_closed, disk_present, write_protect,
                       motor_at_speed};

    pin_filter #(.W(IN_W)) u_filter (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sync(sync)
    );

    straps_t st_in, st;
    pins_t sg;

    assign {st_in, sg} = sync.clean;
    assign st = q.straps;

    // -------------------------------------------------------------
    // Derived conditions
    // -------------------------------------------------------------
    logic selected, sel_rise, idx_lead, spin_ok, cond, needs_toggle, protect_on, use_dir, tunnel, gate_now;
    ready_mode_t mode;

    assign selected = ~sg.drive_sel_b;
    assign sel_rise = selected & ~q.sel_prev;
    assign idx_lead = q.idx_prev_b & ~sg.index_b;
    assign spin_ok = q.idx_seen & q.motor_en & sg.motor_at_speed;
    assign mode = ready_mode_t'({st.ready_mode_strap_b, st.ready_mode_strap_a});
    assign needs_toggle = (mode == RDY_STD) || (mode == RDY_FULL);
    // Direction line counts unless both standard side straps are also fitted
    assign use_dir = st.side_from_direction_strap & ~(st.side_strap_std_a & st.side_strap_std_b);
    assign protect_on = ~(st.protect_inhibit_strap & ~st.protect_enable_strap);
    assign tunnel = st.tunnel_erase_strap & ~st.straddle_erase_strap;
    assign gate_now = q.valid & selected & ~sg.write_enable_b
                      & ~(protect_on & sg.write_protect);

    always_comb begin
        case (mode)
            RDY_STD: cond = sg.latch_closed & sg.disk_present;
            RDY_LATCH: cond = sg.latch_closed;
            RDY_FULL: cond = sg.latch_closed & sg.disk_present & spin_ok;
            RDY_SPIN: cond = sg.latch_closed & spin_ok;
            default: cond = 1'b0;
        endcase
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        d = q;
        d.sel_prev = selected;
        d.idx_prev_b = sg.index_b;

        // One capture after reset, then frozen until the next reset
        if (!q.valid) begin
            if (q.settle == SET_LAST) begin
                d.valid = 1'b1;
                d.straps = st_in;
            end else begin
                d.settle = q.settle + 1'b1;
            end
        end

        // Index presence: lost after a full timeout with no leading edge
        if (idx_lead) begin
            d.idx_timer = '0;
            d.idx_seen = 1'b1;
        end else if (q.idx_timer == IDX_LAST) begin
            d.idx_seen = 1'b0;
        end else begin
            d.idx_timer = q.idx_timer + 1'b1;
        end

        // Removal or change marks ready stale; loss wins over a toggle
        if (sel_rise) begin
            d.stale = 1'b0;
        end
        if (!cond) begin
            d.stale = 1'b1;
        end
        d.ready = q.valid & cond & (~needs_toggle | ~q.stale);

        d.ready_alt_oe = q.valid & st.ready_alt_pin_strap;
        d.ready_alt_b = ~(d.ready & st.ready_alt_pin_strap);
        d.ready_std_oe = q.valid & st.ready_std_pin_strap;
        d.ready_std_b = ~(d.ready & st.ready_std_pin_strap);

        d.side_one = q.valid & (use_dir ? ~sg.direction_b : ~sg.side_select_b);
        d.motor_en = q.valid & (~sg.motor_on_b | (st.motor_by_select_strap & selected));
        d.step_mode = step_sel(st.slow_step_strap, st.self_seek_strap);
        // Host must recalibrate after reselect when power is gated
        d.stepper_pwr = q.valid & (st.stepper_always_strap | ~st.stepper_gated_strap | selected);

        d.special_oe = q.valid & st.disk_present_out_strap & ~st.host_activity_in_strap;
        d.special_b = ~sg.disk_present;
        d.led_on = q.valid & selected & (st.led_select_only_strap
                   | ~(st.activity_path_strap & st.host_activity_in_strap)
                   | ~sg.special_in_b);
        d.door_sol = q.valid & st.door_lock_strap & st.solenoid_fitted_strap & ~sg.door_lock_b;
        d.write_gate = gate_now;

        // Tunnel erase trails the write gate on both edges
        if (!tunnel) begin
            d.erase_on = gate_now;
            d.erase_cnt = '0;
        end else if (q.write_gate == q.erase_on) begin
            d.erase_cnt = '0;
        end else if (q.erase_cnt == ERA_LAST) begin
            d.erase_on = q.write_gate;
            d.erase_cnt = '0;
        end else begin
            d.erase_cnt = q.erase_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q <= '0;
            q.stale <= 1'b1;
            q.ready_alt_b <= 1'b1;
            q.ready_std_b <= 1'b1;
            q.special_b <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign straps_valid = q.valid;
    assign head_side_one = q.side_one;
    assign ready_alt_b = q.ready_alt_b;
    assign ready_alt_oe = q.ready_alt_oe;
    assign ready_std_b = q.ready_std_b;
    assign ready_std_oe = q.ready_std_oe;
    assign motor_enable = q.motor_en;
    assign step_mode = q.step_mode;
    assign stepper_power = q.stepper_pwr;
    assign special_out_b = q.special_b;
    assign special_oe = q.special_oe;
    assign activity_led = q.led_on;
    assign door_solenoid = q.door_sol;
    assign write_gate = q.write_gate;
    assign erase_gate = q.erase_on;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_spin_ready;
        q.idx_seen && q.motor_en && sg.motor_at_speed && sg.latch_closed;
    endsequence

    chk_side_source: assert property (
        $past(q.valid) && q.valid |-> q.side_one == $past(use_dir ? ~sg.direction_b : ~sg.side_select_b))
        else $error("head side from wrong source");
    chk_ready_route: assert property (
        !q.ready_std_b || !q.ready_alt_b |-> q.ready && (q.ready_std_oe || q.ready_alt_oe))
        else $error("ready driven without routing strap");
    chk_std_ready: assert property (
        q.ready && mode == RDY_STD |-> $past(sg.latch_closed && sg.disk_present && !q.stale))
        else $error("standard ready without latch and disk");
    chk_latch_ready: assert property (
        q.valid && mode == RDY_LATCH && sg.latch_closed |=> q.ready)
        else $error("latch mode ready missing");
    chk_full_ready: assert property (
        q.ready && mode == RDY_FULL |-> $past(q.idx_seen && q.motor_en && sg.disk_present))
        else $error("full mode ready without spindle");
    chk_spin_ready: assert property (
        s_spin_ready ##0 (q.valid && mode == RDY_SPIN) |=> q.ready)
        else $error("spin mode ready missing");
    chk_motor_src: assert property (
        q.valid && sg.motor_on_b && !st.motor_by_select_strap |=> !q.motor_en)
        else $error("motor enabled without motor-on");
    chk_step_both: assert property (
        $past(q.valid) && st.slow_step_strap && st.self_seek_strap |-> q.step_mode == STEP_STD_3MS)
        else $error("unused step combination not standard");
    chk_step_seek: assert property (
        $past(q.valid) && !st.slow_step_strap && st.self_seek_strap |-> q.step_mode == STEP_SELF_SEEK)
        else $error("self seek not selected");
    chk_stepper_gate: assert property (
        q.valid && st.stepper_gated_strap && !st.stepper_always_strap && !selected |=> !q.stepper_pwr)
        else $error("stepper powered while deselected");
    chk_special_dir: assert property (
        q.special_oe |-> !st.host_activity_in_strap && st.disk_present_out_strap)
        else $error("special pin driven in input mode");
    chk_led_inuse: assert property (
        q.led_on && st.activity_path_strap && st.host_activity_in_strap && !st.led_select_only_strap
        |-> $past(selected && !sg.special_in_b))
        else $error("activity led without in-use");
    chk_door_lock: assert property (
        q.door_sol |-> $past(st.door_lock_strap && st.solenoid_fitted_strap && !sg.door_lock_b))
        else $error("door solenoid without strap");
    chk_wp_block: assert property (
        q.write_gate && protect_on |-> !$past(sg.write_protect))
        else $error("write gate on protected disk");
    chk_erase_now: assert property (
        $past(q.valid) && !tunnel |-> q.erase_on == q.write_gate)
        else $error("straddle erase not following gate");
    chk_erase_delay: assert property (
        tunnel && $rose(q.erase_on) |-> $past(q.erase_cnt == ERA_LAST && q.write_gate))
        else $error("tunnel erase without delay");
    chk_toggle_clear: assert property (
        $fell(q.stale) |-> q.sel_prev && !$past(q.sel_prev))
        else $error("ready restored without select toggle");
    chk_straps_frozen: assert property (
        $past(q.valid) |-> $stable(q.straps) && q.valid)
        else $error("strap set changed after capture");
    chk_ready_drop: assert property (
        q.valid && !cond |=> !q.ready)
        else $error("ready held after condition lost");

endmodule

// ==== verification/host_model.sv ====
// Host controller model driving the drive's interface lines
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    input wire logic [6:0] cmd,
    output logic [6:0] pins_b,
    output logic track_known
);
    // Open-collector lines: a command pulls its line low, idle lines float high
    initial pins_b = 7'h7f;
    initial track_known = 1'b0;
    always @(negedge core_clk) begin
        pins_b <= ~cmd;
        // Unpowered stepper may drift, so the track is re-found on each reselection
        track_known <= !(pins_b[6] && cmd[6]);
    end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the drive option strap logic
`timescale 1ns/1ps
module tb_top;
    import drive_opt_pkg::*;
    logic core_clk, rst_b;
    straps_t st;
    logic [6:0] cmd, hp;
    logic [3:0] sens;
    logic idx_b = 1'b1;
    localparam int ERA = 16;
    logic straps_valid, head_side_one, ready_alt_b, ready_alt_oe, ready_std_b, ready_std_oe, motor_enable;
    logic stepper_power, special_out_b, special_oe, activity_led, door_solenoid, write_gate, erase_gate;
    step_mode_t step_mode;
    int fails = 0;
    int total_checks = 0;

    host_model host (.core_clk, .cmd, .pins_b(hp), .track_known());
    drive_option_strap_logic #(.INDEX_TIMEOUT_CYC(64), .ERASE_DELAY_CYC(ERA)) dut (.core_clk, .rst_b,
        .side_strap_std_a(st.side_strap_std_a), .side_strap_std_b(st.side_strap_std_b),
        .side_from_direction_strap(st.side_from_direction_strap), .ready_alt_pin_strap(st.ready_alt_pin_strap),
        .ready_std_pin_strap(st.ready_std_pin_strap), .ready_mode_strap_a(st.ready_mode_strap_a),
        .ready_mode_strap_b(st.ready_mode_strap_b), .motor_by_select_strap(st.motor_by_select_strap),
        .slow_step_strap(st.slow_step_strap), .self_seek_strap(st.self_seek_strap),
        .stepper_gated_strap(st.stepper_gated_strap), .stepper_always_strap(st.stepper_always_strap),
        .disk_present_out_strap(st.disk_present_out_strap), .host_activity_in_strap(st.host_activity_in_strap),
        .activity_path_strap(st.activity_path_strap), .led_select_only_strap(st.led_select_only_strap),
        .door_lock_strap(st.door_lock_strap), .solenoid_fitted_strap(st.solenoid_fitted_strap),
        .protect_enable_strap(st.protect_enable_strap), .protect_inhibit_strap(st.protect_inhibit_strap),
        .tunnel_erase_strap(st.tunnel_erase_strap), .straddle_erase_strap(st.straddle_erase_strap),
        .drive_sel_b(hp[6]), .motor_on_b(hp[5]), .direction_b(hp[4]), .side_select_b(hp[3]),
        .write_enable_b(hp[2]), .door_lock_b(hp[1]), .special_in_b(hp[0]), .index_b(idx_b),
        .latch_closed(sens[3]), .disk_present(sens[2]), .write_protect(sens[1]), .motor_at_speed(sens[0]),
        .straps_valid, .head_side_one, .ready_alt_b, .ready_alt_oe, .ready_std_b, .ready_std_oe, .motor_enable,
        .step_mode, .stepper_power, .special_out_b, .special_oe, .activity_led, .door_solenoid, .write_gate,
        .erase_gate);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Straps only count when captured after reset
    task automatic boot(input straps_t s);
        st = s;
        cmd <= 7'h00;
        sens = 4'h0;
        rst_b = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (12) @(negedge core_clk);
    endtask

    // One negedge in the host model plus five cycles of filter and register
    task automatic go(input logic [6:0] c, input logic [3:0] sn);
        cmd <= c;
        sens = sn;
        repeat (8) @(negedge core_clk);
    endtask

    task automatic print_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_latch;
        straps_t s = '0;
        s.ready_mode_strap_a = 1'b1;
        s.ready_std_pin_strap = 1'b1;
        boot(s);
        go(7'h00, 4'h8);
        chk(ready_std_b, 1'b0);
        chk({ready_std_oe, ready_alt_oe}, 2'b10);
        st.ready_std_pin_strap = 1'b0;
        go(7'h00, 4'h0);
        chk(ready_std_b, 1'b1);
        chk(ready_std_oe, 1'b1);
        $display("test latch done");
    endtask

    task automatic t_std;
        straps_t s = '0;
        s.ready_alt_pin_strap = 1'b1;
        boot(s);
        go(7'h40, 4'h0);
        go(7'h40, 4'hc);
        chk(ready_alt_b, 1'b1);
        go(7'h00, 4'hc);
        go(7'h40, 4'hc);
        chk({ready_alt_b, ready_alt_oe}, 2'b01);
        go(7'h40, 4'h8);
        chk(ready_alt_b, 1'b1);
        go(7'h40, 4'hc);
        chk(ready_alt_b, 1'b1);
        $display("test standard ready done");
    endtask

    task automatic t_motor;
        straps_t s = '0;
        s.motor_by_select_strap = 1'b1;
        boot(s);
        go(7'h40, 4'h0);
        chk(motor_enable, 1'b1);
        boot('0);
        go(7'h40, 4'h0);
        chk(motor_enable, 1'b0);
        go(7'h20, 4'h0);
        chk(motor_enable, 1'b1);
        $display("test motor done");
    endtask

    task automatic t_step;
        straps_t s;
        step_mode_t e;
        for (int i = 0; i < 4; i++) begin
            s = '0;
            {s.slow_step_strap, s.self_seek_strap} = 2'(i);
            e = (i == 1) ? STEP_SELF_SEEK : (i == 2) ? STEP_SLOW_6MS : STEP_STD_3MS;
            boot(s);
            chk(step_mode, e);
        end
        $display("test step done");
    endtask

    task automatic t_write;
        straps_t s = '0;
        s.protect_enable_strap = 1'b1;
        s.straddle_erase_strap = 1'b1;
        boot(s);
        go(7'h44, 4'he);
        chk(write_gate, 1'b0);
        go(7'h44, 4'hc);
        chk({write_gate, erase_gate}, 2'b11);
        s.protect_enable_strap = 1'b0;
        s.protect_inhibit_strap = 1'b1;
        boot(s);
        go(7'h44, 4'he);
        chk(write_gate, 1'b1);
        s = '0;
        s.tunnel_erase_strap = 1'b1;
        boot(s);
        go(7'h44, 4'hc);
        repeat (ERA - 3) @(negedge core_clk);
        chk({write_gate, erase_gate}, 2'h2);
        @(negedge core_clk);
        chk(erase_gate, 1'b1);
        $display("test write done");
    endtask

    task automatic t_select;
        straps_t s = '0;
        s.stepper_gated_strap = 1'b1;
        s.led_select_only_strap = 1'b1;
        s.side_strap_std_a = 1'b1;
        s.side_strap_std_b = 1'b1;
        boot(s);
        go(7'h49, 4'h0);
        chk({stepper_power, activity_led, head_side_one}, 3'b111);
        go(7'h00, 4'h0);
        chk({stepper_power, activity_led}, 2'b00);
        $display("test select done");
    endtask

    task automatic t_spin;
        straps_t s = '0;
        s.ready_mode_strap_b = 1'b1;
        s.ready_std_pin_strap = 1'b1;
        boot(s);
        go(7'h60, 4'h0);
        go(7'h60, 4'hd);
        repeat (40) @(negedge core_clk);
        chk(ready_std_b, 1'b1);
        go(7'h20, 4'hd);
        go(7'h60, 4'hd);
        chk(ready_std_b, 1'b0);
        s.ready_mode_strap_a = 1'b1;
        boot(s);
        go(7'h20, 4'h9);
        repeat (40) @(negedge core_clk);
        chk(ready_std_b, 1'b0);
        go(7'h00, 4'h9);
        chk(ready_std_b, 1'b1);
        $display("test spin done");
    endtask

    task automatic t_special;
        straps_t s = '0;
        s.side_from_direction_strap = 1'b1;
        s.disk_present_out_strap = 1'b1;
        s.door_lock_strap = 1'b1;
        s.solenoid_fitted_strap = 1'b1;
        boot(s);
        go(7'h12, 4'h4);
        chk({special_oe, special_out_b, door_solenoid, straps_valid, head_side_one}, 5'h17);
        s.solenoid_fitted_strap = 1'b0;
        s.host_activity_in_strap = 1'b1;
        s.activity_path_strap = 1'b1;
        boot(s);
        go(7'h42, 4'h0);
        chk({special_oe, activity_led, door_solenoid}, 3'h0);
        go(7'h43, 4'h0);
        chk(activity_led, 1'b1);
        $display("test special done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Index edge every 32 cycles, well inside the loss timeout
    always begin
        repeat (16) @(negedge core_clk);
        idx_b = ~idx_b;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #100000;
        fails++;
        print_verdict();
    end

    initial begin
        st = '0;
        cmd = 7'h00;
        sens = 4'h0;
        rst_b = 1'b0;
        repeat (4) @(negedge core_clk);
        t_latch();
        t_std();
        t_motor();
        t_step();
        t_write();
        t_select();
        t_spin();
        t_special();
        print_verdict();
    end
endmodule
